// ---- src/fsts_pkg.sv ----
// Package: constants for the frame scan and tearing-sync block
//
// Contract
// - Frame memory 320 x 480, 18 bits each
// - Host access allowed at any time
// - Same-cycle fetch and host access undisturbed
// - Display columns 0..13F, pages 0..1DF
// - Pixel (0,0) shown top left
// - Scroll areas from scroll commands
// - Tear on enables, tear off disables
// - Mode from tear-on parameter, scanline shapes
// - Mode bit zero; disabled holds output low
// - Mode 0: one vertical pulse per frame
// - Mode 0: high while refresh paused
// - Mode 1: vertical plus 480 line pulses; the last line's pulse merges into the vertical one
// - Mode 1: high while line not refreshed
// - Sleep in holds output low
package fsts_pkg;
    localparam int unsigned COLS      = 320;
    localparam int unsigned LINES     = 480;
    localparam int unsigned PIX_W     = 18;
    localparam int unsigned COL_W     = 9;
    localparam int unsigned LINE_W    = 9;
    localparam int unsigned ADDR_W    = 18;
    localparam logic [COL_W-1:0]  COL_LAST  = 9'h13F;
    localparam logic [LINE_W-1:0] LINE_LAST = 9'h1DF;
    // Cycles per line spent outside the pixel fetch
    localparam int unsigned H_BLANK   = 16;
    // Lines per frame spent with refresh paused
    localparam int unsigned V_BLANK   = 8;
    // Command codes on the command port
    localparam logic [7:0] CMD_SCROLL_AREA  = 8'h33;
    localparam logic [7:0] CMD_TEAR_OFF     = 8'h34;
    localparam logic [7:0] CMD_TEAR_ON      = 8'h35;
    localparam logic [7:0] CMD_SCROLL_START = 8'h37;
    localparam logic [7:0] CMD_TEAR_LINE    = 8'h44;
    localparam logic [7:0] CMD_SLEEP_IN     = 8'h10;
    localparam logic [7:0] CMD_SLEEP_OUT    = 8'h11;
    localparam int unsigned MODE_BIT = 0;
    // Field positions of the three line counts in the area parameter
    localparam int unsigned AREA_TOP_LSB = 18;
    localparam int unsigned AREA_SCR_LSB = 9;
    localparam int unsigned AREA_BOT_LSB = 0;
    localparam logic [LINE_W-1:0] TFA_RST = 9'h000;
    localparam logic [LINE_W-1:0] VSA_RST = 9'h1E0;
    localparam logic [LINE_W-1:0] BFA_RST = 9'h000;
    localparam logic [LINE_W-1:0] VSP_RST = 9'h000;
endpackage : fsts_pkg

// ---- src/fsts_top.sv ----
// Top: frame memory, refresh scan, scrolling and tearing-sync output
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fsts_top
    import fsts_pkg::*;
#(
    parameter int unsigned HBLK = H_BLANK,
    parameter int unsigned VBLK = V_BLANK
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    // Host frame memory port, same clock domain
    input  wire logic              mem_wr,
    input  wire logic              mem_rd,
    input  wire logic [COL_W-1:0]  mem_col,
    input  wire logic [LINE_W-1:0] mem_page,
    input  wire logic [PIX_W-1:0]  mem_wdata,
    output logic      [PIX_W-1:0]  mem_rdata,
    // Command port: one cycle strobe with code and parameter word
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_code,
    input  wire logic [26:0]       cmd_param,
    // Panel side
    output logic      [PIX_W-1:0]  pix_data,
    output logic                   pix_valid,
    output logic      [LINE_W-1:0] pix_line,
    output logic      [COL_W-1:0]  pix_col,
    output logic                   tearing_sync_output
);

    typedef enum logic [1:0] {
        FSTS_ACTIVE = 2'b00,
        FSTS_VBLANK = 2'b01
    } fsts_scan_e;

    // ------------------------------------------------------------
    // Frame memory
    // ------------------------------------------------------------
    logic [PIX_W-1:0] fmem [COLS*LINES];

    function automatic logic [ADDR_W-1:0] addr_of(
        input logic [COL_W-1:0]  c,
        input logic [LINE_W-1:0] p
    );
        addr_of = ADDR_W'(p * COLS + c);
    endfunction : addr_of

    function automatic logic in_range(
        input logic [COL_W-1:0]  c,
        input logic [LINE_W-1:0] p
    );
        in_range = (c <= COL_LAST) && (p <= LINE_LAST);
    endfunction : in_range

    // ------------------------------------------------------------
    // Control state from commands
    // ------------------------------------------------------------
    logic              sync_output_enable_q;
    logic              sync_line_mode_bit_q;
    logic              sleep_q;
    logic [LINE_W-1:0] tear_line_q;
    logic [LINE_W-1:0] top_fixed_lines_q;
    logic [LINE_W-1:0] scrolling_lines_q;
    logic [LINE_W-1:0] bottom_fixed_lines_q;
    logic [LINE_W-1:0] scroll_start_line_q;

    // One decode shared by every command register
    function automatic logic cmd_is(
        input logic       vld,
        input logic [7:0] code,
        input logic [7:0] want
    );
        cmd_is = vld && (code == want);
    endfunction : cmd_is

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync_output_enable_q <= 1'b0;
            sync_line_mode_bit_q <= 1'b0;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_TEAR_ON)) begin
            sync_output_enable_q <= 1'b1;
            sync_line_mode_bit_q <= cmd_param[MODE_BIT];
        end else if (cmd_is(cmd_valid, cmd_code, CMD_TEAR_OFF)) begin
            sync_output_enable_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tear_line_q <= '0;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_TEAR_LINE)) begin
            tear_line_q <= cmd_param[LINE_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sleep_q <= 1'b1;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_SLEEP_IN)) begin
            sleep_q <= 1'b1;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_SLEEP_OUT)) begin
            sleep_q <= 1'b0;
        end
    end

    // Area command is ignored unless the three counts sum to 480
    // A half-applied area would tear the scroll window, so reject whole
    logic [LINE_W-1:0] area_top;
    logic [LINE_W-1:0] area_scr;
    logic [LINE_W-1:0] area_bot;
    logic [LINE_W+1:0] area_sum;
    assign area_top = cmd_param[AREA_TOP_LSB +: LINE_W];
    assign area_scr = cmd_param[AREA_SCR_LSB +: LINE_W];
    assign area_bot = cmd_param[AREA_BOT_LSB +: LINE_W];
    assign area_sum = {2'b00, area_top}
                    + {2'b00, area_scr}
                    + {2'b00, area_bot};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            top_fixed_lines_q    <= TFA_RST;
            scrolling_lines_q    <= VSA_RST;
            bottom_fixed_lines_q <= BFA_RST;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_SCROLL_AREA)
                     && area_sum == (LINE_W+2)'(LINES)) begin
            top_fixed_lines_q    <= area_top;
            scrolling_lines_q    <= area_scr;
            bottom_fixed_lines_q <= area_bot;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scroll_start_line_q <= VSP_RST;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_SCROLL_START)) begin
            scroll_start_line_q <= cmd_param[LINE_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Refresh scan counters
    // ------------------------------------------------------------
    localparam int unsigned HTOT = COLS + HBLK;
    localparam int unsigned HCW  = $clog2(HTOT);

    fsts_scan_e        scan_q;
    logic [HCW-1:0]    hcnt_q;
    logic [LINE_W-1:0] line_q;
    logic [LINE_W-1:0] vb_q;
    logic              line_end;
    assign line_end = (hcnt_q == HCW'(HTOT - 1));

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hcnt_q <= '0;
        end else if (line_end) begin
            hcnt_q <= '0;
        end else begin
            hcnt_q <= hcnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scan_q <= FSTS_VBLANK;
            line_q <= '0;
            vb_q   <= '0;
        end else if (line_end) begin
            case (scan_q)
                FSTS_ACTIVE: begin
                    if (line_q == LINE_LAST) begin
                        scan_q <= FSTS_VBLANK;
                        line_q <= '0;
                        vb_q   <= '0;
                    end else begin
                        line_q <= line_q + 1'b1;
                    end
                end
                default: begin
                    if (vb_q == LINE_W'(VBLK - 1)) begin
                        scan_q <= FSTS_ACTIVE;
                    end else begin
                        vb_q <= vb_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // Map display line to memory page with the scroll window wrapped
    logic [LINE_W-1:0] scr_top;
    logic [LINE_W:0]   scr_pos;
    logic [LINE_W-1:0] src_page;
    assign scr_top = top_fixed_lines_q + scrolling_lines_q;
    always_comb begin
        scr_pos = {1'b0, scroll_start_line_q}
                + {1'b0, line_q} - {1'b0, top_fixed_lines_q};
        if (scr_pos >= {1'b0, scr_top}) begin
            scr_pos = scr_pos - {1'b0, scrolling_lines_q};
        end
        if (line_q < top_fixed_lines_q || line_q >= scr_top) begin
            src_page = line_q;
        end else begin
            src_page = scr_pos[LINE_W-1:0];
        end
    end

    logic              fetch;
    logic [COL_W-1:0]  fcol;
    assign fetch = (scan_q == FSTS_ACTIVE) && (hcnt_q < HCW'(COLS));
    assign fcol  = hcnt_q[COL_W-1:0];

    // ------------------------------------------------------------
    // Memory ports: separate read paths, so neither side stalls
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (mem_wr && in_range(mem_col, mem_page)) begin
            fmem[addr_of(mem_col, mem_page)] <= mem_wdata;
        end
    end

    // Panel sees old data on a same-cycle write: never a torn pixel
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pix_data  <= '0;
            pix_valid <= 1'b0;
            pix_line  <= '0;
            pix_col   <= '0;
        end else begin
            pix_valid <= fetch;
            pix_line  <= line_q;
            pix_col   <= fcol;
            if (fetch) begin
                pix_data <= fmem[addr_of(fcol, src_page)];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_rdata <= '0;
        end else if (mem_rd && in_range(mem_col, mem_page)) begin
            mem_rdata <= fmem[addr_of(mem_col, mem_page)];
        end
    end

    // ------------------------------------------------------------
    // Tearing-sync output
    // ------------------------------------------------------------
    // Scanline setting gates where line pulses begin in mode 1
    logic te_d;
    always_comb begin
        if (!sync_output_enable_q || sleep_q) begin
            te_d = 1'b0;
        end else if (!sync_line_mode_bit_q) begin
            te_d = (scan_q == FSTS_VBLANK);
        end else if (scan_q == FSTS_VBLANK) begin
            te_d = 1'b1;
        end else begin
            te_d = !fetch && (line_q >= tear_line_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tearing_sync_output <= 1'b0;
        end else begin
            tearing_sync_output <= te_d;
        end
    end

endmodule : fsts_top

// ---- test/fsts_properties.sv ----
// Checker: port properties of the frame scan and tearing-sync block
`timescale 1ns/1ps
module fsts_properties
    import fsts_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              mem_rd,
    input wire logic [PIX_W-1:0]  mem_rdata,
    input wire logic              cmd_valid,
    input wire logic [7:0]        cmd_code,
    input wire logic [26:0]       cmd_param,
    input wire logic              pix_valid,
    input wire logic [LINE_W-1:0] pix_line,
    input wire logic [COL_W-1:0]  pix_col,
    input wire logic              tearing_sync_output
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic              slp_q, ten_q, m1_q, quiet, live;
    logic [LINE_W-1:0] tl_q;
    logic [1:0]        age_q;
    // Commands take up to two cycles to reach the pin, so wait for age 3
    always_ff @(posedge ref_clk) begin
        if (srst || cmd_valid)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slp_q <= 1'b1;
            ten_q <= 1'b0;
            m1_q  <= 1'b0;
            tl_q  <= 9'h000;
        end else if (cmd_valid) begin
            case (cmd_code)
                CMD_SLEEP_IN:  slp_q <= 1'b1;
                CMD_SLEEP_OUT: slp_q <= 1'b0;
                CMD_TEAR_OFF:  ten_q <= 1'b0;
                CMD_TEAR_LINE: tl_q  <= cmd_param[8:0];
                CMD_TEAR_ON: begin
                    ten_q <= 1'b1;
                    m1_q  <= cmd_param[MODE_BIT];
                end
                default: ;
            endcase
        end
    end
    assign quiet = age_q == 2'h3 && (slp_q || !ten_q);
    assign live  = age_q == 2'h3 && !slp_q && ten_q;
    sequence s_fetch;
        pix_valid [*3];
    endsequence
    sequence s_low4;
        !tearing_sync_output [*4];
    endsequence
    a_off_low: assert property (quiet |-> !tearing_sync_output)
        else $error("sync output high while disabled or asleep");
    a_fetch_low: assert property (s_fetch |-> !tearing_sync_output)
        else $error("sync output high during pixel fetch");
    a_line_pulse: assert property (live && m1_q && tl_q == 9'h000
        && $fell(pix_valid) |-> ##[0:3] tearing_sync_output)
        else $error("no line pulse in line mode");
    a_mode0_quiet: assert property (live && !m1_q && $fell(pix_valid)
        && $past(pix_line) != LINE_LAST |-> s_low4)
        else $error("line pulse in frame-only mode");
    a_col_step: assert property (pix_valid && pix_col != COL_LAST
        |=> pix_valid && pix_col == $past(pix_col) + 9'h001)
        else $error("pixel column did not advance by one");
    a_line_end: assert property (pix_valid && pix_col == COL_LAST
        |=> !pix_valid)
        else $error("fetch ran past the last column");
    a_line_start: assert property ($rose(pix_valid)
        |-> pix_col == 9'h000 && pix_line <= LINE_LAST)
        else $error("line fetch did not start at column zero");
    a_rdata_hold: assert property (!mem_rd |=> $stable(mem_rdata))
        else $error("read data changed without a read");
endmodule : fsts_properties
bind fsts_top fsts_properties chk_u (.*);

// ---- test/fsts_host_model.sv ----
// Partner model: host that writes column 0 of every frame memory page, started by the sync output
`timescale 1ns/1ps
module fsts_host_model
    import fsts_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              tearing_sync_output,
    input  wire logic [PIX_W-1:0]  mem_rdata,
    output logic                   mem_wr,
    output logic                   mem_rd,
    output logic      [COL_W-1:0]  mem_col,
    output logic      [LINE_W-1:0] mem_page,
    output logic      [PIX_W-1:0]  mem_wdata,
    output logic                   wr_done
);
    initial begin
        mem_wr    = 1'b0;
        mem_rd    = 1'b0;
        mem_col   = 9'h000;
        mem_page  = 9'h000;
        mem_wdata = 18'h00000;
        wr_done   = 1'b0;
        @(negedge srst);
        // Begin only while the panel reports refresh paused
        wait (tearing_sync_output === 1'b1);
        @(posedge ref_clk);
        for (int p = 0; p < LINES; p++) begin
            mem_wr    <= 1'b1;
            mem_page  <= p[8:0];
            mem_wdata <= {9'h000, p[8:0]};
            @(posedge ref_clk);
        end
        mem_wr    <= 1'b0;
        // Released data lines must not keep the last value
        mem_wdata <= ~mem_wdata;
        wr_done   <= 1'b1;
    end
    task automatic rd(input logic [LINE_W-1:0] pg,
                      output logic [PIX_W-1:0] d);
        mem_rd   <= 1'b1;
        mem_page <= pg;
        @(posedge ref_clk);
        mem_rd   <= 1'b0;
        @(posedge ref_clk);
        d = mem_rdata;
    endtask : rd
endmodule : fsts_host_model

// ---- test/fsts_top_tb_top.sv ----
// Testbench: frame scan and tearing-sync block with a host model
`timescale 1ns/1ps
module fsts_top_tb_top import fsts_pkg::*;;
    localparam int LINE_CYC = COLS + 2;
    typedef struct { logic [7:0] c; logic [26:0] p; int n; } fsts_row_s;
    fsts_row_s rows [9] = '{
        '{CMD_TEAR_LINE, 27'h0, 0},
        '{CMD_TEAR_ON, 27'h1, 4},
        '{CMD_TEAR_LINE, 27'h1DF, 0},
        '{CMD_TEAR_LINE, 27'h0, 4},
        '{CMD_TEAR_ON, 27'h2, 0},
        '{CMD_TEAR_ON, 27'h3, 4},
        '{CMD_SLEEP_IN, 27'h0, 0},
        '{CMD_SLEEP_OUT, 27'h0, 4},
        '{CMD_TEAR_OFF, 27'h0, 0}};
    logic              ref_clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0;
    logic [7:0]        cmd_code = 8'h00;
    logic [26:0]       cmd_param = 27'h0;
    logic              mem_wr, mem_rd, pix_valid, tearing_sync_output;
    logic              wr_done, prv;
    logic [COL_W-1:0]  mem_col, pix_col;
    logic [LINE_W-1:0] mem_page, pix_line;
    logic [PIX_W-1:0]  mem_wdata, mem_rdata, pix_data, rd_v;
    int                err_count = 0, num_checks = 0, rises = 0, r0;
    fsts_top #(.HBLK(2), .VBLK(1)) dut_u (.*);
    fsts_host_model host_u (.*);
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [PIX_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic send(input logic [7:0] c, input logic [26:0] p);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_param <= p;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(posedge ref_clk);
    endtask : send
    function automatic logic [PIX_W-1:0] exp_pix(input logic [8:0] l);
        if (l < 9'h002 || l > 9'h1DD)
            return {9'h000, l};
        return PIX_W'(2 + (int'(l) - 2 + 468) % 476);
    endfunction : exp_pix
    // Rises are counted on the falling edge, clear of output updates
    always @(negedge ref_clk) begin
        if (tearing_sync_output && !prv)
            rises++;
        prv = tearing_sync_output;
    end
    always @(posedge ref_clk) begin
        if (!srst && pix_valid && pix_col == 9'h000)
            chk(pix_data, exp_pix(pix_line));
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk(tearing_sync_output, 1'b0);
        send(CMD_SCROLL_AREA, {9'h002, 9'h1DC, 9'h002});
        send(CMD_SCROLL_START, 27'h1D6);
        send(CMD_SLEEP_OUT, 27'h0);
        send(CMD_TEAR_ON, 27'h0);
        repeat (2) @(posedge ref_clk);
        chk(tearing_sync_output, 1'b1);
        @(posedge pix_valid);
        repeat (4) @(posedge ref_clk);
        chk(tearing_sync_output, 1'b0);
        wait (wr_done === 1'b1);
        @(posedge ref_clk);
        host_u.rd(9'h000, rd_v);
        chk(rd_v, 18'h00000);
        host_u.rd(LINE_LAST, rd_v);
        chk(rd_v, {9'h000, LINE_LAST});
        host_u.rd(9'h1E0, rd_v);
        chk(rd_v, {9'h000, LINE_LAST});
        send(CMD_SCROLL_AREA, {9'h001, 9'h001, 9'h001});
        foreach (rows[i]) begin
            send(rows[i].c, rows[i].p);
            repeat (6) @(posedge ref_clk);
            r0 = rises;
            repeat (4 * LINE_CYC) @(posedge ref_clk);
            chk(PIX_W'(rises - r0), PIX_W'(rows[i].n));
        end
        srst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk(tearing_sync_output, 1'b0);
        chk(pix_valid, 1'b0);
        close_out();
    end
endmodule : fsts_top_tb_top
